// file: led_addr_consts.svh
// Constants for the LED controller bus address decoder and its master
`ifndef LED_ADDR_CONSTS_SVH
`define LED_ADDR_CONSTS_SVH
`define ADDR_FIXED_TOP 1'h1
`define GROUP_CALL_RESET 8'hE0
`define SUB_ADDR_1_RESET 8'hE2
`define SUB_ADDR_2_RESET 8'hE4
`define SUB_ADDR_3_RESET 8'hE8
`define GROUP_CALL_EN_RESET 1'h1
`define SUB_EN_RESET 3'h0
`define GENERAL_CALL_ADDR 7'h00
`define RESET_BYTE 8'h06
`define DIR_BIT 0
`define DIR_READ 1'h1
`define DIR_WRITE 1'h0
`define BUS_PERIOD_NS 10000
`define CLK_PERIOD_NS 50
`define HALF_BIT_CYCLES ((`BUS_PERIOD_NS / `CLK_PERIOD_NS) / 2)
`endif

// file: led_addr_pkg.sv
// Types shared by the device end and its address comparator
package led_addr_pkg;
  typedef enum logic [1:0] {
    MATCH_NONE,
    MATCH_OWN,
    MATCH_GROUP,
    MATCH_RESET
  } match_kind_t;
endpackage : led_addr_pkg

// file: led_bus_if.sv
// Two-wire bus carrier between the master and the LED controller
`timescale 1ns/1ps
interface led_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Open drain: a driven low wins, otherwise the pull-up holds the line high
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
  modport device (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : led_bus_if

// file: led_addr_match.sv
// Address byte comparator for own, group and reset addresses
`timescale 1ns/1ps
`include "led_addr_consts.svh"
module led_addr_match import led_addr_pkg::*; (
  // Received address byte
  input wire logic [7:0] addr_byte,
  // Address configuration
  input wire logic [5:0] strap,
  input wire logic [7:0] group_call_address,
  input wire logic [7:0] sub_addr [3],
  input wire logic group_en,
  input wire logic [2:0] sub_en,
  // Result
  output match_kind_t kind
);
  logic [6:0] a;
  logic [2:0] sub_hit;
  assign a = addr_byte[7:1];

  genvar i;
  for (i = 0; i < 3; i++) begin : g_sub
    assign sub_hit[i] = sub_en[i] && (a == sub_addr[i][7:1]);
  end

  always_comb begin
    // Reserved codes get no special treatment, only the strap compare counts
    if (a == {`ADDR_FIXED_TOP, strap}) begin
      kind = MATCH_OWN;
    end else if ((group_en && a == group_call_address[7:1]) || (|sub_hit)) begin
      kind = MATCH_GROUP;
    end else if (a == `GENERAL_CALL_ADDR && addr_byte[`DIR_BIT] == `DIR_WRITE) begin
      kind = MATCH_RESET;
    end else begin
      kind = MATCH_NONE;
    end
  end
endmodule : led_addr_match

// file: led_ctrl_dev.sv
// Device end: bus slave front end of the 16-channel LED controller
`timescale 1ns/1ps
`include "led_addr_consts.svh"
module led_ctrl_dev import led_addr_pkg::*; #(
  parameter int CHANNELS = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Bus
  led_bus_if.device bus,
  // Straps and pins
  input wire logic [5:0] addr_strap,
  input wire logic external_clock_in,
  input wire logic output_enable_n,
  // Configuration from the register block
  input wire logic cfg_we,
  input wire logic [2:0] cfg_sel,
  input wire logic [7:0] cfg_data,
  input wire logic [3:0] cfg_enables,
  // PWM drive from the engines
  input wire logic [CHANNELS-1:0] pwm_level,
  // Outputs
  output logic [CHANNELS-1:0] pwm_driver_out,
  output logic [7:0] reg_pointer,
  output logic pointer_valid,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  output logic rd_request,
  output logic sw_reset_pulse
);
  if (CHANNELS != 16) begin : g_bad_channels
    $error("led_ctrl_dev serves exactly 16 channels");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_PTR, ST_DATA, ST_RST, ST_IGNORE
  } dev_state_t;

  // ------------------------------------------------------------
  // Line sampling and bus conditions
  // ------------------------------------------------------------
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end
  assign scl_rise = bus.scl && !scl_q;
  assign scl_fall = !bus.scl && scl_q;
  assign start_seen = bus.scl && scl_q && sda_q && !bus.sda;
  assign stop_seen = bus.scl && scl_q && !sda_q && bus.sda;

  // ------------------------------------------------------------
  // Address registers
  // ------------------------------------------------------------
  logic [7:0] group_q;
  logic [7:0] sub_q [3];
  logic group_en_q;
  logic [2:0] sub_en_q;
  logic soft_rst_q;
  logic cfg_rst;
  assign cfg_rst = !nrst || soft_rst_q;
  always_ff @(posedge clk_sys) begin
    if (cfg_rst) begin
      group_q <= `GROUP_CALL_RESET;
      sub_q[0] <= `SUB_ADDR_1_RESET;
      sub_q[1] <= `SUB_ADDR_2_RESET;
      sub_q[2] <= `SUB_ADDR_3_RESET;
      group_en_q <= `GROUP_CALL_EN_RESET;
      sub_en_q <= `SUB_EN_RESET;
    end else if (cfg_we) begin
      if (cfg_sel == 3'h3) begin
        group_q <= cfg_data;
      end else if (cfg_sel < 3'h3) begin
        sub_q[cfg_sel[1:0]] <= cfg_data;
      end else begin
        group_en_q <= cfg_enables[3];
        sub_en_q <= cfg_enables[2:0];
      end
    end
  end

  match_kind_t kind;
  logic [7:0] shift_q;
  led_addr_match u_match (
    .addr_byte(shift_q),
    .strap(addr_strap),
    .group_call_address(group_q),
    .sub_addr(sub_q),
    .group_en(group_en_q),
    .sub_en(sub_en_q),
    .kind(kind)
  );

  // ------------------------------------------------------------
  // Byte engine
  // ------------------------------------------------------------
  dev_state_t state_q, next_after_ack_q;
  logic [3:0] bit_q;
  logic ack_drive_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      next_after_ack_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      ack_drive_q <= 1'h0;
      reg_pointer <= 8'h00;
      pointer_valid <= 1'h0;
      wr_data <= 8'h00;
      wr_strobe <= 1'h0;
      rd_request <= 1'h0;
      soft_rst_q <= 1'h0;
    end else begin
      wr_strobe <= 1'h0;
      rd_request <= 1'h0;
      soft_rst_q <= 1'h0;
      if (start_seen) begin
        state_q <= ST_ADDR;
        bit_q <= 4'h0;
        ack_drive_q <= 1'h0;
      end else if (stop_seen) begin
        state_q <= ST_IDLE;
        ack_drive_q <= 1'h0;
      end else if (scl_rise && state_q inside {ST_ADDR, ST_PTR, ST_DATA, ST_RST}) begin
        shift_q <= {shift_q[6:0], bus.sda};
        bit_q <= bit_q + 4'h1;
      end else if (scl_fall && state_q == ST_ACK) begin
        ack_drive_q <= 1'h0;
        state_q <= next_after_ack_q;
        bit_q <= 4'h0;
      end else if (scl_fall && bit_q == 4'h8) begin
        bit_q <= 4'h0;
        unique case (state_q)
          ST_ADDR: begin
            if (kind == MATCH_NONE) begin
              state_q <= ST_IGNORE;
            end else begin
              ack_drive_q <= 1'h1;
              state_q <= ST_ACK;
              if (kind == MATCH_RESET) begin
                next_after_ack_q <= ST_RST;
              end else if (shift_q[`DIR_BIT] == `DIR_READ) begin
                next_after_ack_q <= ST_IGNORE;
                rd_request <= 1'h1;
              end else begin
                next_after_ack_q <= ST_PTR;
              end
            end
          end
          ST_PTR: begin
            reg_pointer <= shift_q;
            pointer_valid <= 1'h1;
            ack_drive_q <= 1'h1;
            state_q <= ST_ACK;
            next_after_ack_q <= ST_DATA;
          end
          ST_DATA: begin
            wr_data <= shift_q;
            wr_strobe <= 1'h1;
            ack_drive_q <= 1'h1;
            state_q <= ST_ACK;
            next_after_ack_q <= ST_DATA;
          end
          ST_RST: begin
            // Any other byte after the general call is left unanswered
            if (shift_q == `RESET_BYTE) begin
              ack_drive_q <= 1'h1;
              soft_rst_q <= 1'h1;
              state_q <= ST_ACK;
              next_after_ack_q <= ST_IGNORE;
            end else begin
              state_q <= ST_IGNORE;
            end
          end
          default: state_q <= ST_IGNORE;
        endcase
      end
      if (soft_rst_q) begin
        pointer_valid <= 1'h0;
        reg_pointer <= 8'h00;
      end
    end
  end

  assign sw_reset_pulse = soft_rst_q;
  assign bus.sda_s_o = 1'h0;
  assign bus.sda_s_oe = ack_drive_q;

  // ------------------------------------------------------------
  // Output stage
  // ------------------------------------------------------------
  // The external clock only feeds the PWM engines, which live elsewhere
  logic unused_clk;
  assign unused_clk = external_clock_in;
  always_ff @(posedge clk_sys) begin
    if (cfg_rst) begin
      pwm_driver_out <= '0;
    end else begin
      pwm_driver_out <= output_enable_n ? '0 : pwm_level;
    end
  end
endmodule : led_ctrl_dev

// file: led_bus_master.sv
// Master end: issues address, pointer and data bytes on the two-wire bus
`timescale 1ns/1ps
`include "led_addr_consts.svh"
module led_bus_master #(
  parameter int HALF_BIT = `HALF_BIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Bus
  led_bus_if.master bus,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_byte0,
  input wire logic [7:0] cmd_byte1,
  input wire logic [1:0] cmd_count,
  // Result
  output logic done,
  output logic [2:0] ack_flags
);
  if (HALF_BIT < 2) begin : g_bad_half_bit
    $error("led_bus_master needs at least two cycles per half bit");
  end

  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} mst_state_t;
  mst_state_t state_q;
  logic [15:0] tick_q;
  logic phase_q;
  logic [2:0] bit_q;
  logic [1:0] byte_q, count_q;
  logic [7:0] bytes_q [3];
  logic scl_q, sda_q;
  logic tick;
  assign tick = (tick_q == 16'(HALF_BIT - 1));
  assign cmd_ready = (state_q == M_IDLE);

  always_ff @(posedge clk_sys) begin
    if (!nrst || state_q == M_IDLE || tick) begin
      tick_q <= 16'h0000;
    end else begin
      tick_q <= tick_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_q <= M_IDLE;
      phase_q <= 1'h0;
      bit_q <= 3'h7;
      byte_q <= 2'h0;
      count_q <= 2'h0;
      bytes_q[0] <= 8'h00;
      bytes_q[1] <= 8'h00;
      bytes_q[2] <= 8'h00;
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      done <= 1'h0;
      ack_flags <= 3'h0;
    end else begin
      done <= 1'h0;
      unique case (state_q)
        M_IDLE: if (cmd_valid) begin
          // Address byte always leads, then up to two payload bytes
          bytes_q[0] <= cmd_addr;
          bytes_q[1] <= cmd_byte0;
          bytes_q[2] <= cmd_byte1;
          count_q <= (cmd_addr[`DIR_BIT] == `DIR_READ) ? 2'h0 : cmd_count;
          byte_q <= 2'h0;
          bit_q <= 3'h7;
          ack_flags <= 3'h0;
          phase_q <= 1'h0;
          sda_q <= 1'h0;
          state_q <= M_START;
        end
        M_START: if (tick) begin
          scl_q <= 1'h0;
          state_q <= M_BIT;
        end
        M_BIT, M_ACK: if (tick) begin
          phase_q <= !phase_q;
          if (!phase_q) begin
            scl_q <= 1'h1;
            if (state_q == M_ACK) begin
              ack_flags[byte_q] <= !bus.sda;
            end
          end else begin
            scl_q <= 1'h0;
            if (state_q == M_BIT) begin
              if (bit_q == 3'h0) begin
                state_q <= M_ACK;
              end else begin
                bit_q <= bit_q - 3'h1;
              end
            end else if (byte_q == count_q || !ack_flags[byte_q]) begin
              state_q <= M_STOP;
            end else begin
              byte_q <= byte_q + 2'h1;
              bit_q <= 3'h7;
              state_q <= M_BIT;
            end
          end
        end
        M_STOP: if (tick) begin
          phase_q <= !phase_q;
          if (!phase_q) begin
            scl_q <= 1'h1;
          end else begin
            // Data rises a half bit after the clock, so the far end sees a STOP
            sda_q <= 1'h1;
            state_q <= M_IDLE;
            done <= 1'h1;
          end
        end
        default: state_q <= M_IDLE;
      endcase
    end
  end

  logic sda_bit;
  always_comb begin
    unique case (state_q)
      M_BIT: sda_bit = bytes_q[byte_q][bit_q];
      M_ACK: sda_bit = 1'h1;
      M_STOP: sda_bit = 1'h0;
      M_START: sda_bit = 1'h0;
      default: sda_bit = sda_q;
    endcase
  end
  assign bus.scl_o = scl_q;
  assign bus.scl_oe = !scl_q;
  assign bus.sda_m_o = 1'h0;
  assign bus.sda_m_oe = !sda_bit;
endmodule : led_bus_master

// file: led_addr_checker.sv
// Concurrent checks on the two-wire link between master and device
`timescale 1ns/1ps
module led_addr_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Link signals
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Bit position within the current byte
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // Restarts on a START so a stray pulse cannot shift the ack slot for long
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      bit_cnt_q <= 4'h0;
    end else if (scl && scl_q && sda_q && !sda) begin
      bit_cnt_q <= 4'h0;
    end else if (scl && !scl_q) begin
      bit_cnt_q <= (bit_cnt_q == 4'h8) ? 4'h0 : bit_cnt_q + 4'h1;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  ack_slot_a: assert property ($rose(sda_s_oe) |-> bit_cnt_q == 4'h8)
    else $error("device drove data outside the ack slot");
  bus_cond_a: assert property ((scl && scl_q && (sda != sda_q)) |-> !sda_s_oe)
    else $error("device drove data during start or stop");
  dev_hold_a: assert property ((scl && scl_q) |-> $stable(sda_s_oe))
    else $error("device changed data while clock high");
  ack_low_a: assert property (sda_s_oe |-> !sda_s_o)
    else $error("device drove data high");
  ack_len_a: assert property ($rose(sda_s_oe) |-> sda_s_oe[*4])
    else $error("ack shorter than half a bit");
  ack_release_a: assert property ($rose(sda_s_oe) |-> ##[4:20] !sda_s_oe)
    else $error("ack not released in time");
  scl_high_a: assert property ($rose(scl) |-> scl[*3])
    else $error("clock high phase too short");
  scl_low_a: assert property ($fell(scl) |-> (!scl)[*3])
    else $error("clock low phase too short");
  master_release_a: assert property ((sda_s_oe && scl) |-> !sda_m_oe)
    else $error("master drove data during the ack slot");
endmodule : led_addr_checker

// file: led_pwm_i2c_address_decoder_bench.sv
// Bench for the address decoder with master and device ends joined
`timescale 1ns/1ps
module led_pwm_i2c_address_decoder_bench;
  logic clk_sys, nrst, cfg_we, output_enable_n, cmd_valid, cmd_ready, done;
  logic pointer_valid, wr_strobe, rd_request, sw_reset_pulse;
  logic [5:0] addr_strap;
  logic [2:0] cfg_sel, ack, ack_flags;
  logic [3:0] cfg_enables;
  logic [1:0] cmd_count;
  logic [7:0] cfg_data, cmd_addr, cmd_byte0, cmd_byte1, reg_pointer, wr_data;
  logic [15:0] pwm_level, pwm_driver_out;
  int fail_count, samples_checked, rd_cnt, rst_cnt, wr_cnt;
  led_bus_if bus_w();
  led_ctrl_dev u_led_ctrl_dev (.clk_sys(clk_sys), .nrst(nrst), .bus(bus_w.device), .addr_strap(addr_strap),
    .external_clock_in(1'h0), .output_enable_n(output_enable_n), .cfg_we(cfg_we), .cfg_sel(cfg_sel),
    .cfg_data(cfg_data), .cfg_enables(cfg_enables), .pwm_level(pwm_level), .pwm_driver_out(pwm_driver_out),
    .reg_pointer(reg_pointer), .pointer_valid(pointer_valid), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_request(rd_request), .sw_reset_pulse(sw_reset_pulse));
  led_bus_master #(.HALF_BIT(4)) u_led_bus_master (.clk_sys(clk_sys), .nrst(nrst), .bus(bus_w.master),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_byte0(cmd_byte0),
    .cmd_byte1(cmd_byte1), .cmd_count(cmd_count), .done(done), .ack_flags(ack_flags));
  led_addr_checker chk (.clk_sys(clk_sys), .nrst(nrst), .scl_o(bus_w.scl_o), .scl_oe(bus_w.scl_oe),
    .sda_m_o(bus_w.sda_m_o), .sda_m_oe(bus_w.sda_m_oe), .sda_s_o(bus_w.sda_s_o), .sda_s_oe(bus_w.sda_s_oe),
    .scl(bus_w.scl), .sda(bus_w.sda));
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Strobes last one cycle, so they are counted as they pass
  always @(posedge clk_sys) begin
    if (rd_request === 1'h1) rd_cnt++;
    if (sw_reset_pulse === 1'h1) rst_cnt++;
    if (wr_strobe === 1'h1) wr_cnt++;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task xfer(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1, input logic [1:0] n);
    int i;
    @(negedge clk_sys);
    cmd_addr = a;
    cmd_byte0 = b0;
    cmd_byte1 = b1;
    cmd_count = n;
    cmd_valid = 1'h1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 1'h0;
    check(16'(cmd_ready), 16'h0);
    for (i = 0; i < 600 && done !== 1'h1; i++) @(negedge clk_sys);
    if (i == 600) begin
      fail_count++;
      $display("[ERR] %0t transfer never finished", $time);
    end
    ack = ack_flags;
  endtask : xfer
  task probe(input logic [7:0] a, input logic e);
    xfer(a, 8'h00, 8'h00, 2'h0);
    check({15'h0, ack[0]}, {15'h0, e});
  endtask : probe
  task cfg(input logic [2:0] sel, input logic [7:0] data);
    @(negedge clk_sys);
    cfg_sel = sel;
    cfg_data = data;
    cfg_we = 1'h1;
    @(negedge clk_sys);
    cfg_we = 1'h0;
  endtask : cfg
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_pwm;
    @(negedge clk_sys);
    output_enable_n = 1'h0;
    pwm_level = 16'hA5C3;
    repeat (3) @(negedge clk_sys);
    check(pwm_driver_out, 16'hA5C3);
    output_enable_n = 1'h1;
    repeat (3) @(negedge clk_sys);
    check(pwm_driver_out, 16'h0000);
    $display("output gate test done");
  endtask : t_pwm
  task automatic t_own;
    // None of the strap settings below lands on the group call address
    logic [5:0] s [5] = '{6'h2A, 6'h00, 6'h3F, 6'h3C, 6'h38};
    int r;
    int w;
    // The last three straps land on reserved bus addresses
    for (int k = 0; k < 5; k++) begin
      addr_strap = s[k];
      probe({1'h1, s[k], 1'h0}, 1'h1);
      probe({1'h1, s[k] ^ 6'h01, 1'h0}, 1'h0);
    end
    addr_strap = 6'h2A;
    w = wr_cnt;
    xfer(8'hD4, 8'h05, 8'h3C, 2'h2);
    check(16'(ack), 16'h7);
    check(16'(reg_pointer), 16'h05);
    check(16'(pointer_valid), 16'h1);
    check(16'(wr_cnt), 16'(w + 1));
    check(16'(wr_data), 16'h3C);
    r = rd_cnt;
    xfer(8'hD5, 8'h00, 8'h00, 2'h0);
    check(16'(ack), 16'h1);
    check(16'(rd_cnt), 16'(r + 1));
    $display("own address test done");
  endtask : t_own
  task automatic t_group;
    logic [7:0] off [6] = '{8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE8, 8'hE9};
    probe(8'hE0, 1'h1);
    probe(8'hE1, 1'h1);
    for (int k = 0; k < 6; k++) probe(off[k], 1'h0);
    xfer(8'hE0, 8'h11, 8'h00, 2'h1);
    check(16'(reg_pointer), 16'h11);
    $display("group address test done");
  endtask : t_group
  task t_sub;
    cfg_enables = 4'h9;
    cfg(3'h4, 8'h00);
    probe(8'hE2, 1'h1);
    probe(8'hE4, 1'h0);
    cfg(3'h1, 8'hC6);
    cfg_enables = 4'h7;
    cfg(3'h4, 8'h00);
    probe(8'hC7, 1'h1);
    probe(8'hE8, 1'h1);
    probe(8'hE0, 1'h0);
    $display("sub address test done");
  endtask : t_sub
  task t_reset;
    int r;
    r = rst_cnt;
    probe(8'h01, 1'h0);
    probe(8'hE8, 1'h1);
    xfer(8'h00, 8'h07, 8'h00, 2'h1);
    check(16'(ack), 16'h1);
    xfer(8'h00, 8'h06, 8'h00, 2'h1);
    check(16'(ack), 16'h3);
    check(16'(rst_cnt), 16'(r + 1));
    check(16'(pointer_valid), 16'h0);
    check(16'(reg_pointer), 16'h00);
    probe(8'hC6, 1'h0);
    probe(8'hE8, 1'h0);
    probe(8'hE0, 1'h1);
    $display("software reset test done");
  endtask : t_reset
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    nrst = 1'h0;
    {cfg_we, cfg_sel, cfg_data, cmd_valid, cmd_addr, cmd_byte0, cmd_byte1, cmd_count} = '0;
    cfg_enables = 4'h8;
    addr_strap = 6'h2A;
    output_enable_n = 1'h1;
    pwm_level = 16'h0000;
    repeat (6) @(negedge clk_sys);
    nrst = 1'h1;
    t_pwm;
    t_own;
    t_group;
    t_sub;
    t_reset;
    complete_run;
  end
  // Roughly eight times the expected run length
  initial begin
    repeat (25000) @(posedge clk_sys);
    fail_count++;
    complete_run;
  end
endmodule : led_pwm_i2c_address_decoder_bench
